// ===== include/hc_pkg.sv
// hc_pkg: constants and types shared by the two-wire host controller files.
// assumes a 50 MHz ref_clk and a 32-bit AXI4-Lite register port.
package hc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 2500;
  // quarter bit time rounded up, so the clock never runs above 400 kHz
  localparam int QUARTER_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ==========================================================
  // device addressing and byte framing
  localparam logic [5:0] DEV_ADDR_HIGH = 6'h16;
  localparam logic       DIR_WRITE     = 1'h0;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic [3:0] DIR_SLOT      = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

  // ==========================================================
  // device register pointers, reset values and control fields
  localparam logic [7:0] PTR_MAKER_ID_0        = 8'h00;
  localparam logic [7:0] PTR_MAKER_ID_1        = 8'h01;
  localparam logic [7:0] PTR_MAKER_ID_2        = 8'h02;
  localparam logic [7:0] PTR_MAKER_ID_3        = 8'h03;
  localparam logic [7:0] PTR_PART_ID_0         = 8'h04;
  localparam logic [7:0] PTR_PART_ID_1         = 8'h05;
  localparam logic [7:0] PTR_PART_ID_2         = 8'h06;
  localparam logic [7:0] PTR_PART_ID_3         = 8'h07;
  localparam logic [7:0] PTR_LINE_PULL_CONTROL = 8'h10;
  localparam logic [7:0] PTR_BUS_POWER_CONTROL = 8'h11;
  localparam logic [7:0] PTR_BUS_STATUS        = 8'h13;
  localparam logic [7:0] PTR_IRQ_ENABLE        = 8'h14;
  localparam logic [7:0] PTR_IRQ_EDGE_SELECT   = 8'h15;
  localparam logic [7:0] PTR_IRQ_PENDING       = 8'h16;
  localparam logic [7:0] LINE_PULL_RESET       = 8'h00;
  localparam logic [7:0] BUS_POWER_RESET       = 8'h01;
  localparam int         POWER_DOWN_BIT        = 0;
  localparam int         TIMED_BUS_CHARGE_BIT  = 1;
  localparam int         AUTO_SWAP_ENABLE_BIT  = 2;

  // ==========================================================
  // host registers (byte addresses) and fields
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_POINTER  = 8'h04;
  localparam logic [7:0] OFF_WDATA    = 8'h08;
  localparam logic [7:0] OFF_CONFIG   = 8'h0C;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_RDATA    = 8'h14;
  localparam int         CTRL_GO      = 0;
  localparam int         CTRL_READ    = 1;
  localparam int         CFG_ADDR_LSB = 0;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_DONE    = 1;
  localparam int         STAT_NACK    = 2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TX, ST_RX, ST_STOP} link_state_t;
  typedef enum logic [2:0] {SEQ_ADDR_WR, SEQ_POINTER, SEQ_DATA, SEQ_ADDR_RD, SEQ_READ} seq_t;
  typedef enum logic [1:0] {PH_SET, PH_RISE, PH_HIGH, PH_FALL} phase_t;

endpackage : hc_pkg

// ===== logic/pin_sync.sv
// pin_sync: two-flop synchroniser for pins arriving from outside ref_clk.
// assumes idle lines read high, so the flops reset to ones.
`timescale 1ns/1ps

module pin_sync
#(
  parameter int WIDTH = 2
)
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one pin");
  end

  // only the second stage is ever read
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta    <= '1;
      pinSync <= '1;
    end
    else
    begin
      meta    <= pinIn;
      pinSync <= meta;
    end
  end

endmodule : pin_sync

// ===== logic/quarter_tick.sv
// quarter_tick: one-cycle tick every QUARTER clocks, paces the serial clock.
// assumes restart is a single-cycle pulse from the same clock domain.
`timescale 1ns/1ps

module quarter_tick
#(
  parameter int QUARTER = hc_pkg::QUARTER_CYC
)
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // phase control
  input  wire logic restart,
  output logic      tick
);

  localparam int CW = $clog2(QUARTER + 1);

  logic [CW-1:0] count;

  if (QUARTER < 2) begin : g_bad_quarter
    $error("quarter_tick needs at least two cycles per quarter");
  end

  // restart aligns the first quarter of a transfer to a full length
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= '0;
      tick  <= 1'h0;
    end
    else if (restart || count == CW'(QUARTER - 1))
    begin
      count <= '0;
      tick  <= !restart;
    end
    else
    begin
      count <= count + 1'h1;
      tick  <= 1'h0;
    end
  end

endmodule : quarter_tick

// ===== logic/otg_host_ctrl.sv
// otg_host_ctrl: two-wire bus master for the dual-role support device's register
// file; software orders single-register reads and writes over AXI4-Lite.
// assumes pull-ups on both lines outside and pins resolved from the enables.
`timescale 1ns/1ps

module otg_host_ctrl
#(
  parameter int ADDR_W  = 8,
  parameter int QUARTER = hc_pkg::QUARTER_CYC
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // axi4-lite write channels
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read channels
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // two-wire link, open drain: a line is pulled low while its enable is low
  input  wire logic              sclIn,
  output logic                   sclOut,
  output logic                   sclOeB,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOeB
);

  localparam int LCW    = $clog2(2 * QUARTER + 2);
  localparam int Q_WAIT = QUARTER + 1;

  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must hold the 8-bit register offsets");
  end

  // ==========================================================
  // declarations
  hc_pkg::link_state_t state;
  hc_pkg::seq_t        step;
  hc_pkg::phase_t      phase;
  logic [3:0]          bitCnt;
  logic [7:0]          shift;
  logic [7:0]          rxByte;
  logic [7:0]          pointer;
  logic [7:0]          wrByte;
  logic                readMode;
  logic                addrLsb;
  logic                done;
  logic                nack;
  logic                sclS;
  logic                sdaS;
  logic                tick;
  logic                adv;
  logic                busy;
  logic                goAccept;
  logic                ackEdge;
  logic                awHeld;
  logic                wHeld;
  logic                wLane;
  logic                doWrite;
  logic [ADDR_W-1:0]   wAddr;
  logic [7:0]          wByte;
  logic [31:0]         next_rdata;
  logic [LCW-1:0]      sclLowCnt;

  // ==========================================================
  // helpers
  function automatic logic [7:0] txByte(input hc_pkg::seq_t s, input logic lsb,
                                        input logic [7:0] ptr, input logic [7:0] dat);
    case (s)
      hc_pkg::SEQ_ADDR_WR: txByte = {hc_pkg::DEV_ADDR_HIGH, lsb, hc_pkg::DIR_WRITE};
      hc_pkg::SEQ_ADDR_RD: txByte = {hc_pkg::DEV_ADDR_HIGH, lsb, hc_pkg::DIR_READ};
      hc_pkg::SEQ_POINTER: txByte = ptr;
      default:             txByte = dat;
    endcase
  endfunction : txByte

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = a == ADDR_W'(hc_pkg::OFF_CTRL)   || a == ADDR_W'(hc_pkg::OFF_POINTER) ||
               a == ADDR_W'(hc_pkg::OFF_WDATA)  || a == ADDR_W'(hc_pkg::OFF_CONFIG)  ||
               a == ADDR_W'(hc_pkg::OFF_STATUS) || a == ADDR_W'(hc_pkg::OFF_RDATA);
  endfunction : isMapped

  function automatic logic wrHit(input logic [7:0] off);
    wrHit = doWrite && wLane && wAddr == ADDR_W'(off);
  endfunction : wrHit

  // ==========================================================
  // pin sampling and bit pacing
  pin_sync #(.WIDTH(2)) u_pin_sync
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pinIn   ({sclIn, sdaIn}),
    .pinSync ({sclS, sdaS})
  );

  quarter_tick #(.QUARTER(QUARTER)) u_quarter_tick
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .restart (goAccept),
    .tick    (tick)
  );

  // open drain: only ever pull low
  assign sclOut = 1'h0;
  assign sdaOut = 1'h0;

  // a slave holding the clock low stretches the high quarter
  assign adv      = tick && !(phase == hc_pkg::PH_HIGH && !sclS);
  assign busy     = state != hc_pkg::ST_IDLE;
  assign goAccept = wrHit(hc_pkg::OFF_CTRL) && wByte[hc_pkg::CTRL_GO] && !busy;
  assign ackEdge  = adv && phase == hc_pkg::PH_FALL && bitCnt == hc_pkg::ACK_SLOT &&
                    (state == hc_pkg::ST_TX || state == hc_pkg::ST_RX);

  // ==========================================================
  // link sequencer
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state  <= hc_pkg::ST_IDLE;
      step   <= hc_pkg::SEQ_ADDR_WR;
      phase  <= hc_pkg::PH_SET;
      bitCnt <= '0;
      shift  <= '0;
      sclOeB <= 1'h1;
      sdaOeB <= 1'h1;
    end
    else if (state == hc_pkg::ST_IDLE)
    begin
      phase  <= hc_pkg::PH_SET;
      bitCnt <= '0;
      if (goAccept)
      begin
        state <= hc_pkg::ST_START;
        step  <= hc_pkg::SEQ_ADDR_WR;
      end
    end
    else if (adv)
    begin
      phase <= hc_pkg::phase_t'(phase + 2'h1);
      case (state)
        hc_pkg::ST_START:
          unique case (phase)
            hc_pkg::PH_SET:  sdaOeB <= 1'h1;
            hc_pkg::PH_RISE: sclOeB <= 1'h1;
            hc_pkg::PH_HIGH: sdaOeB <= 1'h0;
            hc_pkg::PH_FALL:
            begin
              sclOeB <= 1'h0;
              state  <= hc_pkg::ST_TX;
              shift  <= txByte(step, addrLsb, pointer, wrByte);
            end
          endcase
        hc_pkg::ST_STOP:
          unique case (phase)
            hc_pkg::PH_SET:  sdaOeB <= 1'h0;
            hc_pkg::PH_RISE: sclOeB <= 1'h1;
            hc_pkg::PH_HIGH: sdaOeB <= 1'h0;
            hc_pkg::PH_FALL:
            begin
              sdaOeB <= 1'h1;
              state  <= hc_pkg::ST_IDLE;
            end
          endcase
        default:
          // byte transfer, either direction
          unique case (phase)
            // data moves only in the low quarter; receiver side is released
            hc_pkg::PH_SET:  sdaOeB <= state == hc_pkg::ST_RX || bitCnt == hc_pkg::ACK_SLOT ||
                                       shift[7];
            hc_pkg::PH_RISE: sclOeB <= 1'h1;
            hc_pkg::PH_HIGH: sclOeB <= 1'h1;
            hc_pkg::PH_FALL:
            begin
              sclOeB <= 1'h0;
              if (bitCnt != hc_pkg::ACK_SLOT)
              begin
                bitCnt <= bitCnt + 4'h1;
                shift  <= {shift[6:0], sdaS};
              end
              else
              begin
                bitCnt <= '0;
                // a refused byte or the single read byte ends the access
                if (state == hc_pkg::ST_RX || sdaS)
                  state <= hc_pkg::ST_STOP;
                else
                  case (step)
                    hc_pkg::SEQ_ADDR_WR:
                    begin
                      step  <= hc_pkg::SEQ_POINTER;
                      shift <= txByte(hc_pkg::SEQ_POINTER, addrLsb, pointer, wrByte);
                    end
                    hc_pkg::SEQ_POINTER:
                      if (readMode)
                      begin
                        step  <= hc_pkg::SEQ_ADDR_RD;
                        state <= hc_pkg::ST_START;
                      end
                      else
                      begin
                        step  <= hc_pkg::SEQ_DATA;
                        shift <= txByte(hc_pkg::SEQ_DATA, addrLsb, pointer, wrByte);
                      end
                    hc_pkg::SEQ_ADDR_RD:
                    begin
                      step  <= hc_pkg::SEQ_READ;
                      state <= hc_pkg::ST_RX;
                    end
                    default: state <= hc_pkg::ST_STOP;
                  endcase
              end
            end
          endcase
      endcase
    end
  end

  // ==========================================================
  // order registers, frozen while a transfer runs
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readMode <= 1'h0;
      pointer  <= '0;
      wrByte   <= '0;
      addrLsb  <= 1'h0;
    end
    else if (!busy)
    begin
      if (wrHit(hc_pkg::OFF_CTRL))
        readMode <= wByte[hc_pkg::CTRL_READ];
      if (wrHit(hc_pkg::OFF_POINTER))
        pointer <= wByte;
      if (wrHit(hc_pkg::OFF_WDATA))
        wrByte <= wByte;
      if (wrHit(hc_pkg::OFF_CONFIG))
        addrLsb <= wByte[hc_pkg::CFG_ADDR_LSB];
    end
  end

  // ==========================================================
  // result flags: a setting event beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done   <= 1'h0;
      nack   <= 1'h0;
      rxByte <= '0;
    end
    else
    begin
      done <= (done && !(wrHit(hc_pkg::OFF_STATUS) && wByte[hc_pkg::STAT_DONE])) ||
              (adv && state == hc_pkg::ST_STOP && phase == hc_pkg::PH_FALL);
      nack <= (nack && !(wrHit(hc_pkg::OFF_STATUS) && wByte[hc_pkg::STAT_NACK])) ||
              (ackEdge && state == hc_pkg::ST_TX && sdaS);
      if (ackEdge && state == hc_pkg::ST_RX)
        rxByte <= shift;
    end
  end

  // ==========================================================
  // axi4-lite slave
  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeld <= 1'h0;
      wHeld  <= 1'h0;
      wLane  <= 1'h0;
      wAddr  <= '0;
      wByte  <= '0;
      bvalid <= 1'h0;
      bresp  <= hc_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld <= 1'h1;
        wAddr  <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld <= 1'h1;
        wByte <= wdata[7:0];
        wLane <= wstrb[0];
      end
      if (doWrite)
      begin
        awHeld <= 1'h0;
        wHeld  <= 1'h0;
        bvalid <= 1'h1;
        bresp  <= isMapped(wAddr) ? hc_pkg::RESP_OKAY : hc_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'h0;
    end
  end

  always_comb
  begin
    next_rdata = '0;
    case (araddr)
      ADDR_W'(hc_pkg::OFF_CTRL):    next_rdata[hc_pkg::CTRL_READ]    = readMode;
      ADDR_W'(hc_pkg::OFF_POINTER): next_rdata[7:0]                  = pointer;
      ADDR_W'(hc_pkg::OFF_WDATA):   next_rdata[7:0]                  = wrByte;
      ADDR_W'(hc_pkg::OFF_CONFIG):  next_rdata[hc_pkg::CFG_ADDR_LSB] = addrLsb;
      ADDR_W'(hc_pkg::OFF_STATUS):
      begin
        next_rdata[hc_pkg::STAT_BUSY] = busy;
        next_rdata[hc_pkg::STAT_DONE] = done;
        next_rdata[hc_pkg::STAT_NACK] = nack;
      end
      ADDR_W'(hc_pkg::OFF_RDATA):   next_rdata[7:0]                  = rxByte;
      default:                      next_rdata                       = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid <= 1'h0;
      rdata  <= '0;
      rresp  <= hc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'h1;
      rdata  <= next_rdata;
      rresp  <= isMapped(araddr) ? hc_pkg::RESP_OKAY : hc_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'h0;
  end

  // ==========================================================
  // checks; the low-time counter exists only for them
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sclLowCnt <= '0;
    else if (sclOeB)
      sclLowCnt <= '0;
    else if (sclLowCnt != '1)
      sclLowCnt <= sclLowCnt + 1'h1;
  end

  a_idle_released: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == hc_pkg::ST_IDLE |-> sclOeB && sdaOeB)
    else $error("bus not released while idle");

  a_start_shape: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(sdaOeB) && sclOeB |-> state == hc_pkg::ST_START ##[1:Q_WAIT] !sclOeB)
    else $error("data fell with clock high outside a start");

  a_stop_shape: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(sdaOeB) && sclOeB |-> state == hc_pkg::ST_IDLE && $past(state) == hc_pkg::ST_STOP)
    else $error("data rose with clock high outside a stop");

  a_data_steady: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state == hc_pkg::ST_TX || state == hc_pkg::ST_RX) && sclOeB && $past(sclOeB)
      |-> $stable(sdaOeB))
    else $error("data moved while clock high");

  a_ack_released: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == hc_pkg::ST_TX && bitCnt == hc_pkg::ACK_SLOT && phase != hc_pkg::PH_SET
      |-> sdaOeB)
    else $error("master drove data in the acknowledge slot");

  a_read_nack: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == hc_pkg::ST_RX && phase != hc_pkg::PH_SET |-> sdaOeB)
    else $error("master pulled data during a read byte or its ninth bit");

  a_dir_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == hc_pkg::ST_TX && bitCnt == hc_pkg::DIR_SLOT && phase == hc_pkg::PH_HIGH &&
    (step == hc_pkg::SEQ_ADDR_WR || step == hc_pkg::SEQ_ADDR_RD)
      |-> sdaOeB == (step == hc_pkg::SEQ_ADDR_RD))
    else $error("direction bit wrong");

  a_write_ends: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ackEdge && step == hc_pkg::SEQ_DATA |=> state == hc_pkg::ST_STOP ##[1:Q_WAIT] !sdaOeB)
    else $error("write did not stop after its data byte");

  a_low_time: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(sclOeB) |-> sclLowCnt >= LCW'(2 * QUARTER))
    else $error("clock low time shorter than two quarters");

endmodule : otg_host_ctrl

// ===== test/otg_dev_model.sv
// otg_dev_model: behavioural two-wire register device standing at the far end.
// assumes resolved, pulled-up lines; it only ever pulls data low.
`timescale 1ns/1ps

module otg_dev_model
#(
  parameter logic       ADDR_LSB  = 1'h0,
  parameter logic [7:0] ID_BASE   = 8'hC0,  // arbitrary identity values
  parameter int         CHARGE_NS = 105_000_000  // self-timed charge pulse length
)
(
  // resolved lines
  input  wire logic scl,
  input  wire logic sda,
  // open-drain pull, low pulls data low
  output logic      sdaPullB
);
  // ==========================================================
  // register file
  logic [7:0] regs [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] dout;
  logic       sel;
  logic       rdPh;
  int         cnt;
  int         nByte;
  event       chargeOn;

  initial
  begin
    foreach (regs[i]) regs[i] = (i < 8) ? ID_BASE + 8'(i) : 8'h00;
    regs[8'h11] = 8'h01;
    sdaPullB = 1'b1;
    sel = 1'b0;
  end

  // ==========================================================
  // framing
  always @(negedge sda) if (scl === 1'b1)
  begin
    sel = 1'b1;
    rdPh = 1'b0;
    cnt = 0;
    nByte = 0;
    sdaPullB = 1'b1;
  end

  always @(posedge sda) if (scl === 1'b1) sel = 1'b0;

  // bits are counted on the rising clock, so the fall that ends a start is not a bit
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    if (sel) cnt = cnt + 1;
  end

  // the self-timed charge bit drops on its own once the pulse has run
  always @(chargeOn) #(CHARGE_NS) regs[8'h11] = regs[8'h11] & 8'hFD;

  // changes only after clock falls, so data is steady while it is high
  always @(negedge scl) if (sel)
  begin
    if (cnt == 8 && !(rdPh && nByte == 1))
    begin
      if (nByte == 0) sel = (sh[7:1] == {6'h16, ADDR_LSB});
      if (nByte == 0) rdPh = sh[0];
      if (nByte == 1) ptr = sh;
      if (nByte == 2 && (ptr == 8'h10 || ptr == 8'h11 || ptr == 8'h14 || ptr == 8'h15))
        regs[ptr] = sh;
      if (nByte == 2 && ptr == 8'h10 && !sh[2]) regs[8'h13] = regs[8'h13] & 8'h9F;
      if (nByte == 2 && ptr == 8'h11 && sh[1]) -> chargeOn;
      sdaPullB = !sel;
    end
    else if (cnt == 9)
    begin
      cnt = 0;
      nByte = nByte + 1;
      dout = regs[ptr];
      sdaPullB = (rdPh && nByte == 1) ? dout[7] : 1'b1;
    end
    else if (rdPh && nByte == 1) sdaPullB = (cnt == 8) ? 1'b1 : dout[7 - cnt];
  end
endmodule : otg_dev_model

// ===== test/test_otg_host_ctrl.sv
// test_otg_host_ctrl: register-level bench for the two-wire host controller.
// assumes otg_dev_model on the far side with its address strap low.
`timescale 1ns/1ps

module test_otg_host_ctrl;
  // ==========================================================
  // signals
  localparam logic [7:0] ID_BASE = 8'hC0;  // arbitrary identity values
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sclOeB, sdaOeB, devPullB;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, v;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, r;
  int          badCount = 0, nChecks = 0, cycles = 0;
  wire         scl = sclOeB;
  wire         sda = sdaOeB & devPullB;
  logic [7:0]  rdPtr [8] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h12, 8'h08, 8'h13};
  logic [7:0]  rdExp [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60};
  logic [7:0]  wrPtr [7] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h02, 8'h16, 8'h13};
  logic [7:0]  wrExp [7] = '{8'hA5, 8'h3C, 8'hFF, 8'h81, ID_BASE + 8'h02, 8'h00, 8'h60};

  otg_host_ctrl #(.ADDR_W(8), .QUARTER(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sclIn(scl), .sclOut(), .sclOeB(sclOeB), .sdaIn(sda),
    .sdaOut(), .sdaOeB(sdaOeB));
  otg_dev_model #(.ADDR_LSB(1'h0), .ID_BASE(ID_BASE), .CHARGE_NS(30000)) devModel (.scl(scl),
    .sda(sda), .sdaPullB(devPullB));

  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      badCount = badCount + 1;
      reportAndStop();
    end
  end

  // ==========================================================
  // tasks
  task automatic reportAndStop();
    if (badCount == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : reportAndStop

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    nChecks = nChecks + 1;
    if (got !== exp)
    begin
      badCount = badCount + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  // one device access, then status, idle lines and the returned byte
  task automatic devAccess(input logic [7:0] p, input logic [7:0] d, input logic rd,
                           input logic nack);
    axiWrite(hc_pkg::OFF_POINTER, {24'h0, p});
    axiWrite(hc_pkg::OFF_WDATA, {24'h0, d});
    axiWrite(hc_pkg::OFF_CTRL, {30'h0, rd, 1'b1});
    do axiRead(hc_pkg::OFF_STATUS); while (v[hc_pkg::STAT_BUSY] !== 1'b0);
    checkVal(v, {29'h0, nack, 2'h2});
    checkVal({30'h0, scl, sda}, 32'h0000_0003);
    axiWrite(hc_pkg::OFF_STATUS, 32'h0000_0006);
    axiRead(hc_pkg::OFF_RDATA);
  endtask : devAccess

  // ==========================================================
  // sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    // far side has already finished both role swaps
    devModel.regs[8'h13] = 8'h60;
    axiWrite(8'h18, 32'h0000_0001);
    checkVal({30'h0, r}, {30'h0, hc_pkg::RESP_SLVERR});
    for (int i = 0; i < 16; i++)
    begin
      devAccess((i < 8) ? 8'(i) : rdPtr[i - 8], 8'h00, 1'b1, 1'b0);
      checkVal(v, {24'h0, (i < 8) ? ID_BASE + 8'(i) : rdExp[i - 8]});
    end
    for (int i = 0; i < 7; i++) devAccess(wrPtr[i], (i < 4) ? wrExp[i] : 8'hFF, 1'b0, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      devAccess(wrPtr[i], 8'h00, 1'b1, 1'b0);
      checkVal(v, {24'h0, wrExp[i]});
    end
    axiWrite(hc_pkg::OFF_CONFIG, 32'h0000_0001);
    devAccess(8'h10, 8'h00, 1'b0, 1'b1);
    axiWrite(hc_pkg::OFF_CONFIG, 32'h0000_0000);
    devAccess(8'h10, 8'h00, 1'b1, 1'b0);
    checkVal(v, 32'h0000_00A5);
    devAccess(8'h10, 8'h00, 1'b0, 1'b0);
    devAccess(8'h13, 8'h00, 1'b1, 1'b0);
    checkVal(v, 32'h0000_0000);
    devAccess(8'h11, 8'h02, 1'b0, 1'b0);
    devAccess(8'h11, 8'h00, 1'b1, 1'b0);
    checkVal(v, 32'h0000_0002);
    repeat (2000) @(posedge ref_clk);
    devAccess(8'h11, 8'h00, 1'b1, 1'b0);
    checkVal(v, 32'h0000_0000);
    reportAndStop();
  end
endmodule : test_otg_host_ctrl
